//--- hdl/pcr_pkg.sv
// Constants for the peripheral settings register block.
// Assumes a 32-bit classic Wishbone slave port and a 40 MHz device clock.
package pcr_pkg;

    // The register answers at this one byte address and nowhere else
    localparam logic [11:0] PCR_SETTINGS_ADDR  = 12'h0AA;
    localparam logic [31:0] PCR_SETTINGS_RESET = 32'h4000_0000;

    // Field positions
    localparam int PCR_POS_PARITY    = 31;
    localparam int PCR_POS_SSM_OFF   = 30;
    localparam int PCR_POS_LIMIT_LSB = 22;
    localparam int PCR_POS_LIMIT_EN  = 21;
    localparam int PCR_POS_DIR_LSB   = 19;
    localparam int PCR_POS_DIR_CHG   = 18;
    localparam int PCR_POS_SELFTEST  = 17;
    localparam int PCR_POS_GAP_LSB   = 13;
    localparam int PCR_POS_CAP_LSB   = 10;
    localparam int PCR_POS_RANGE     = 9;
    localparam int PCR_POS_ALERT_OFF = 8;

    // Decoded values; all but the slow range pair match the reset contents of the register
    localparam logic [13:0] PCR_LIMIT_MA_RST  = 14'h007D;
    localparam logic [9:0]  PCR_GAP_RST       = 10'h019;
    localparam logic [6:0]  PCR_CAP_RST       = 7'h00;
    localparam logic [16:0] PCR_WIDE_MIN_HZ   = 17'h0_0145;
    localparam logic [16:0] PCR_WIDE_MAX_HZ   = 17'h1_7318;
    localparam logic [16:0] PCR_SLOW_MIN_HZ   = 17'h0_000A;
    localparam logic [16:0] PCR_SLOW_MAX_HZ   = 17'h0_0145;

    // Pin level that means clockwise when direction comes from the pin
    localparam logic PCR_DIR_PIN_CW_LEVEL = 1'b0;

    typedef enum logic [1:0] {
        PCR_DIR_PIN_A     = 2'b00,
        PCR_DIR_FORCE_CW  = 2'b01,
        PCR_DIR_FORCE_CCW = 2'b10,
        PCR_DIR_PIN_B     = 2'b11
    } pcr_dir_src_t;

endpackage

//--- hdl/pcr_peripheral_settings.sv
// Peripheral settings register with a classic Wishbone slave and decoded field outputs.
// Assumes a synchronous direction pin and alarm request, one clock, async active-high reset.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RULE1: Register decoded at byte address AAh, reset value 40000000h.
// RULE2: Bit 30 set disables clock spreading; set after reset.
// RULE3: Bit 21 enables bus current limit; four-bit code picks 0.125 A to 8 A.
// RULE4: Bits 20-19: 0 and 3 follow pin, 1 forces clockwise, 2 counter-clockwise.
// RULE5: Bit 18 picks stop-and-detect or reverse drive on a direction pin change.
// RULE6: Bit 17 enables the power-up self-test; clear after reset.
// RULE7: Bits 16-13 set the speed gap beyond which active braking applies.
// RULE8: Bits 12-10 set the modulation index cap: 0%, then 40% to 100%.
// RULE9: Bit 9 picks 325 Hz to 95 kHz when clear, 10 Hz to 325 Hz set.
// RULE10: Bit 8 set disables the alarm output pin; clear after reset.
// RULE11: All 32 bits hold their last write and read back as stored.
module pcr_peripheral_settings
    import pcr_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [11:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Motor control side
    input  wire logic        dirPin,
    input  wire logic        alarmReq,
    output logic             clockSpreadingEn,
    output logic             busLimitEn,
    output logic      [3:0]  busLimitCode,
    output logic      [13:0] busLimitMilliamps,
    output logic             motorClockwise,
    output logic             reverseDriveReq,
    output logic             stopAndDetectReq,
    output logic             powerupCheckEn,
    output logic      [9:0]  brakeSpeedGapTenths,
    output logic      [6:0]  brakeModulationCapPct,
    output logic             speedRangeLow,
    output logic      [16:0] speedMinHz,
    output logic      [16:0] speedMaxHz,
    output logic             alarmPin
);

    typedef struct packed {
        logic        ack;
        logic [31:0] rdData;
        logic [31:0] cfg;
        logic [13:0] limitMa;
        logic [9:0]  gapTenths;
        logic [6:0]  capPct;
        logic [16:0] minHz;
        logic [16:0] maxHz;
        logic        clockwise;
        logic        armed;
        logic        dirPinSeen;
        logic        reverseReq;
        logic        stopReq;
        logic        alarmOut;
    } pcr_state_t;

    localparam pcr_state_t PCR_STATE_RST = '{
        ack:        1'b0,
        rdData:     32'h0000_0000,
        cfg:        PCR_SETTINGS_RESET,
        limitMa:    PCR_LIMIT_MA_RST,
        gapTenths:  PCR_GAP_RST,
        capPct:     PCR_CAP_RST,
        minHz:      PCR_WIDE_MIN_HZ,
        maxHz:      PCR_WIDE_MAX_HZ,
        clockwise:  PCR_DIR_PIN_CW_LEVEL == 1'b0,
        armed:      1'b0,
        dirPinSeen: 1'b0,
        reverseReq: 1'b0,
        stopReq:    1'b0,
        alarmOut:   1'b0
    };

    pcr_state_t st_ff;
    pcr_state_t nxt_st;

    logic        busReq;
    logic        addrHit;
    logic        wrTake;
    logic [31:0] cfgQ;

    assign busReq  = cyc_i & stb_i;
    assign cfgQ    = st_ff.cfg;
    assign wrTake  = busReq & st_ff.ack & we_i & addrHit;

    // Full byte-address match; byte lanes still come from sel_i
    always_comb begin
        if (adr_i == PCR_SETTINGS_ADDR) begin
            addrHit = 1'b1;  // [RULE1]
        end else begin
            addrHit = 1'b0;
        end
    end

    function automatic logic [13:0] limitToMa(input logic [3:0] code);
        case (code)
            4'h0:    limitToMa = 14'h007D;
            4'h1:    limitToMa = 14'h00FA;
            4'h2:    limitToMa = 14'h01F4;
            4'h3:    limitToMa = 14'h03E8;
            4'h4:    limitToMa = 14'h05DC;
            4'h5:    limitToMa = 14'h07D0;
            4'h6:    limitToMa = 14'h09C4;
            4'h7:    limitToMa = 14'h0BB8;
            4'h8:    limitToMa = 14'h0DAC;
            4'h9:    limitToMa = 14'h0FA0;
            4'hA:    limitToMa = 14'h1194;
            4'hB:    limitToMa = 14'h1388;
            4'hC:    limitToMa = 14'h157C;
            4'hD:    limitToMa = 14'h1770;
            4'hE:    limitToMa = 14'h1B58;
            default: limitToMa = 14'h1F40;
        endcase
    endfunction

    // Speed gap in tenths of a percent, so 2.5 % stays exact
    function automatic logic [9:0] gapToTenths(input logic [3:0] code);
        case (code)
            4'h0:    gapToTenths = 10'h019;
            4'h1:    gapToTenths = 10'h032;
            4'h2:    gapToTenths = 10'h064;
            4'h3:    gapToTenths = 10'h096;
            4'h4:    gapToTenths = 10'h0C8;
            4'h5:    gapToTenths = 10'h0FA;
            4'h6:    gapToTenths = 10'h12C;
            4'h7:    gapToTenths = 10'h15E;
            4'h8:    gapToTenths = 10'h190;
            4'h9:    gapToTenths = 10'h1C2;
            4'hA:    gapToTenths = 10'h1F4;
            4'hB:    gapToTenths = 10'h258;
            4'hC:    gapToTenths = 10'h2BC;
            4'hD:    gapToTenths = 10'h320;
            4'hE:    gapToTenths = 10'h384;
            default: gapToTenths = 10'h3E8;
        endcase
    endfunction

    function automatic logic [6:0] capToPct(input logic [2:0] code);
        case (code)
            3'h0:    capToPct = 7'h00;
            3'h1:    capToPct = 7'h28;
            3'h2:    capToPct = 7'h32;
            3'h3:    capToPct = 7'h3C;
            3'h4:    capToPct = 7'h46;
            3'h5:    capToPct = 7'h50;
            3'h6:    capToPct = 7'h5A;
            default: capToPct = 7'h64;
        endcase
    endfunction

    always_comb begin
        pcr_dir_src_t dirSrc;
        logic         pinDriven;
        logic         pinChanged;
        dirSrc     = PCR_DIR_PIN_A;
        pinDriven  = 1'b0;
        pinChanged = 1'b0;
        nxt_st     = st_ff;

        // One-cycle ack, then dropped so the master sees a clean release
        nxt_st.ack    = busReq & ~st_ff.ack;
        nxt_st.rdData = 32'h0000_0000;
        if (busReq && !st_ff.ack && !we_i && addrHit) begin
            nxt_st.rdData = st_ff.cfg;  // [RULE11]
        end

        // Write lands only at the edge where the master samples ack
        if (wrTake) begin
            for (int b = 0; b < 4; b++) begin
                if (sel_i[b]) begin
                    nxt_st.cfg[b*8 +: 8] = dat_i[b*8 +: 8];  // [RULE11]
                end
            end
        end

        // Decoded values track the register with no extra lag
        nxt_st.limitMa   = limitToMa(nxt_st.cfg[PCR_POS_LIMIT_LSB +: 4]);  // [RULE3]
        nxt_st.gapTenths = gapToTenths(nxt_st.cfg[PCR_POS_GAP_LSB +: 4]);  // [RULE7]
        nxt_st.capPct    = capToPct(nxt_st.cfg[PCR_POS_CAP_LSB +: 3]);     // [RULE8]
        if (nxt_st.cfg[PCR_POS_RANGE]) begin
            nxt_st.minHz = PCR_SLOW_MIN_HZ;  // [RULE9]
            nxt_st.maxHz = PCR_SLOW_MAX_HZ;
        end else begin
            nxt_st.minHz = PCR_WIDE_MIN_HZ;  // [RULE9]
            nxt_st.maxHz = PCR_WIDE_MAX_HZ;
        end

        dirSrc = pcr_dir_src_t'(nxt_st.cfg[PCR_POS_DIR_LSB +: 2]);
        case (dirSrc)
            PCR_DIR_FORCE_CW: begin
                nxt_st.clockwise = 1'b1;  // [RULE4]
            end
            PCR_DIR_FORCE_CCW: begin
                nxt_st.clockwise = 1'b0;  // [RULE4]
            end
            default: begin
                nxt_st.clockwise = (dirPin == PCR_DIR_PIN_CW_LEVEL);  // [RULE4]
                pinDriven        = 1'b1;
            end
        endcase

        // First cycle after reset only captures the pin, so no false change fires
        nxt_st.armed      = 1'b1;
        nxt_st.dirPinSeen = dirPin;
        pinChanged        = st_ff.armed & (dirPin != st_ff.dirPinSeen) & pinDriven;
        nxt_st.reverseReq = pinChanged & st_ff.cfg[PCR_POS_DIR_CHG];   // [RULE5]
        nxt_st.stopReq    = pinChanged & ~st_ff.cfg[PCR_POS_DIR_CHG];  // [RULE5]

        nxt_st.alarmOut = alarmReq & ~st_ff.cfg[PCR_POS_ALERT_OFF];  // [RULE10]
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= PCR_STATE_RST;  // [RULE1]
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ack_o                 = st_ff.ack;
    assign dat_o                 = st_ff.rdData;
    assign clockSpreadingEn      = ~st_ff.cfg[PCR_POS_SSM_OFF];  // [RULE2]
    assign busLimitEn            = st_ff.cfg[PCR_POS_LIMIT_EN];  // [RULE3]
    assign busLimitCode          = st_ff.cfg[PCR_POS_LIMIT_LSB +: 4];
    assign busLimitMilliamps     = st_ff.limitMa;
    assign motorClockwise        = st_ff.clockwise;
    assign reverseDriveReq       = st_ff.reverseReq;
    assign stopAndDetectReq      = st_ff.stopReq;
    assign powerupCheckEn        = st_ff.cfg[PCR_POS_SELFTEST];  // [RULE6]
    assign brakeSpeedGapTenths   = st_ff.gapTenths;
    assign brakeModulationCapPct = st_ff.capPct;
    assign speedRangeLow         = st_ff.cfg[PCR_POS_RANGE];
    assign speedMinHz            = st_ff.minHz;
    assign speedMaxHz            = st_ff.maxHz;
    assign alarmPin              = st_ff.alarmOut;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    decode_read_a: assert property ( // [RULE1]
        busReq && !ack_o && !we_i && addrHit |=> ack_o && dat_o == $past(cfgQ))
        else $error("Settings read did not return stored value");

    unmapped_read_a: assert property ( // [RULE1]
        busReq && !ack_o && !addrHit |=> ack_o && dat_o == 32'h0000_0000 ##1 !ack_o)
        else $error("Unmapped access answered wrongly");

    spread_off_a: assert property ( // [RULE2]
        $rose(cfgQ[PCR_POS_SSM_OFF]) |-> !clockSpreadingEn)
        else $error("Clock spreading not stopped by set bit");

    limit_top_a: assert property ( // [RULE3]
        busLimitEn && busLimitCode == 4'hF |-> busLimitMilliamps == 14'h1F40)
        else $error("Top limit code is not 8 A");

    dir_force_a: assert property ( // [RULE4]
        cfgQ[PCR_POS_DIR_LSB +: 2] == 2'b10 |-> !motorClockwise ##1
        (cfgQ[PCR_POS_DIR_LSB +: 2] != 2'b01 || motorClockwise))
        else $error("Forced direction not applied");

    dir_change_a: assert property ( // [RULE5]
        reverseDriveReq |-> !stopAndDetectReq && $past(cfgQ[PCR_POS_DIR_CHG])
        && $past(dirPin) != $past(dirPin, 2))
        else $error("Reverse drive without pin change");

    selftest_follow_a: assert property ( // [RULE6]
        wrTake && sel_i[2] |=> powerupCheckEn == $past(dat_i[PCR_POS_SELFTEST]))
        else $error("Self-test enable not written");

    gap_low_a: assert property ( // [RULE7]
        cfgQ[PCR_POS_GAP_LSB +: 4] == 4'h0 |-> brakeSpeedGapTenths == 10'h019)
        else $error("Lowest speed gap is not 2.5 percent");

    cap_step_a: assert property ( // [RULE8]
        cfgQ[PCR_POS_CAP_LSB +: 3] != 3'h0 |-> brakeModulationCapPct ==
        7'(7'h1E + 7'h0A * cfgQ[PCR_POS_CAP_LSB +: 3]))
        else $error("Modulation cap step wrong");

    range_slow_a: assert property ( // [RULE9]
        speedRangeLow |-> speedMinHz == 17'h0_000A && speedMaxHz == 17'h0_0145)
        else $error("Slow speed range wrong");

    alert_off_a: assert property ( // [RULE10]
        $past(cfgQ[PCR_POS_ALERT_OFF]) |-> !alarmPin)
        else $error("Alarm pin driven while disabled");

    hold_value_a: assert property ( // [RULE11]
        !wrTake |=> $stable(cfgQ))
        else $error("Register changed without a write");

    ack_pulse_a: assert property ( // [RULE11]
        ack_o |=> !ack_o)
        else $error("Bus acknowledge held longer than one cycle");

    unmapped_write_a: assert property ( // [RULE1]
        busReq && we_i && !addrHit |=> $stable(cfgQ))
        else $error("Write to another address changed the register");

    write_lands_a: assert property ( // [RULE11]
        wrTake && sel_i == 4'hF |=> cfgQ == $past(dat_i))
        else $error("Full-word write not stored");

    spread_write_a: assert property ( // [RULE2]
        wrTake && sel_i[3] |=> clockSpreadingEn == !$past(dat_i[PCR_POS_SSM_OFF]))
        else $error("Clock spreading does not follow written bit");

    limit_low_a: assert property ( // [RULE3]
        busLimitCode == 4'h0 |-> busLimitMilliamps == PCR_LIMIT_MA_RST)
        else $error("Lowest limit code is not 0.125 A");

    dir_pin_a: assert property ( // [RULE4]
        !$past(rst) && (cfgQ[PCR_POS_DIR_LSB +: 2] == 2'b00 ||
        cfgQ[PCR_POS_DIR_LSB +: 2] == 2'b11) |->
        motorClockwise == ($past(dirPin) == PCR_DIR_PIN_CW_LEVEL))
        else $error("Direction does not follow the pin");

    stop_change_a: assert property ( // [RULE5]
        stopAndDetectReq |-> !reverseDriveReq && !$past(cfgQ[PCR_POS_DIR_CHG])
        && $past(dirPin) != $past(dirPin, 2))
        else $error("Stop request without pin change");

    gap_top_a: assert property ( // [RULE7]
        cfgQ[PCR_POS_GAP_LSB +: 4] == 4'hF |-> brakeSpeedGapTenths == 10'h3E8)
        else $error("Top speed gap is not 100 percent");

    range_write_a: assert property ( // [RULE9]
        wrTake && sel_i[1] |=> speedRangeLow == $past(dat_i[PCR_POS_RANGE]))
        else $error("Speed range bit not written");

    alert_on_a: assert property ( // [RULE10]
        !$past(rst) && !$past(cfgQ[PCR_POS_ALERT_OFF]) |-> alarmPin == $past(alarmReq))
        else $error("Alarm pin does not follow request");

endmodule

`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the peripheral settings register block.
// Assumes one Wishbone answer per request and decoded outputs that follow a write.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pcr_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = '0;
    logic [3:0]  sel = '0;
    logic [31:0] datW = '0;
    logic        dirPin = 1'b0;
    logic        alarmReq = 1'b0;
    logic        ack, spreadEn, limEn, cw, revReq, stopReq, checkEn, rangeLow, alarmPin;
    logic [31:0] datR, word, rd;
    logic [3:0]  limCode;
    logic [13:0] limMa;
    logic [9:0]  gap;
    logic [6:0]  cap;
    logic [16:0] minHz, maxHz;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          revCnt, stopCnt;
    integer      seed = 32'heaac;

    pcr_peripheral_settings i_pcr_peripheral_settings (.clock(clock), .rst(rst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW),
        .dat_o(datR), .ack_o(ack), .dirPin(dirPin), .alarmReq(alarmReq),
        .clockSpreadingEn(spreadEn), .busLimitEn(limEn), .busLimitCode(limCode),
        .busLimitMilliamps(limMa), .motorClockwise(cw), .reverseDriveReq(revReq),
        .stopAndDetectReq(stopReq), .powerupCheckEn(checkEn), .brakeSpeedGapTenths(gap),
        .brakeModulationCapPct(cap), .speedRangeLow(rangeLow), .speedMinHz(minHz),
        .speedMaxHz(maxHz), .alarmPin(alarmPin));

    always #12.5 clock = ~clock;

    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A hung handshake must still reach the closing report
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        datW <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = datR;
        chk("bus ack", 32'h0000_0001, 32'(ack));
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    function automatic int expMa(input int c);
        if (c <= 2) return 125 << c;
        if (c <= 13) return 500 * (c - 1);
        return (c == 14) ? 7000 : 8000;
    endfunction

    function automatic int expGap(input int c);
        if (c == 0) return 25;
        return (c <= 10) ? 50 * c : 600 + 100 * (c - 11);
    endfunction

    task automatic check_fields(input logic [31:0] w);
        chk("spreading", 32'(!w[30]), 32'(spreadEn));
        chk("limit enable", 32'(w[21]), 32'(limEn));
        chk("limit code", 32'(w[25:22]), 32'(limCode));
        chk("limit mA", expMa(int'(w[25:22])), 32'(limMa));
        chk("self test", 32'(w[17]), 32'(checkEn));
        chk("speed gap", expGap(int'(w[16:13])), 32'(gap));
        chk("mod cap", (w[12:10] == 0) ? 0 : 30 + 10 * w[12:10], 32'(cap));
        chk("range", 32'(w[9]), 32'(rangeLow));
        chk("min Hz", w[9] ? 10 : 325, 32'(minHz));
        chk("max Hz", w[9] ? 325 : 95000, 32'(maxHz));
    endtask

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, PCR_SETTINGS_ADDR, 4'hF, '0, rd);
        chk("reset word", PCR_SETTINGS_RESET, rd);
        check_fields(PCR_SETTINGS_RESET);
        chk("alarm pin", 32'h0000_0000, 32'(alarmPin));
        // Neighbouring word must neither store nor answer with data
        bus(1'b1, PCR_SETTINGS_ADDR ^ 12'h002, 4'hF, 32'hFFFF_FFFF, rd);
        bus(1'b0, PCR_SETTINGS_ADDR ^ 12'h002, 4'hF, '0, rd);
        chk("unmapped read", 32'h0000_0000, rd);
        bus(1'b0, PCR_SETTINGS_ADDR, 4'hF, '0, rd);
        chk("after unmapped", PCR_SETTINGS_RESET, rd);
        $display("test reset and decode done");
        for (int i = 0; i < 16; i++) begin
            word = $random(seed);
            word[25:22] = 4'(i);
            word[16:13] = 4'(i);
            word[12:10] = 3'(i);
            bus(1'b1, PCR_SETTINGS_ADDR, 4'hF, word, rd);
            bus(1'b0, PCR_SETTINGS_ADDR, 4'hF, '0, rd);
            chk("readback", word, rd);
            check_fields(word);
        end
        bus(1'b1, PCR_SETTINGS_ADDR, 4'b0101, 32'hFFFF_FFFF, rd);
        bus(1'b1, PCR_SETTINGS_ADDR, 4'b0000, 32'h0000_0000, rd);
        bus(1'b0, PCR_SETTINGS_ADDR, 4'hF, '0, rd);
        chk("byte lanes", word | 32'h00FF_00FF, rd);
        $display("test field sweep done");
        for (int m = 0; m < 8; m++) begin
            word = PCR_SETTINGS_RESET;
            word[20:19] = 2'(m / 2);
            word[18] = m[0];
            bus(1'b1, PCR_SETTINGS_ADDR, 4'hF, word, rd);
            repeat (2) @(posedge clock);
            dirPin <= ~dirPin;
            revCnt = 0;
            stopCnt = 0;
            repeat (4) begin
                @(negedge clock);
                revCnt += int'(revReq === 1'b1);
                stopCnt += int'(stopReq === 1'b1);
            end
            chk("reverse pulses", 32'(int'((m / 2) % 3 == 0 && m[0])), 32'(revCnt));
            chk("stop pulses", 32'(int'((m / 2) % 3 == 0 && !m[0])), 32'(stopCnt));
            chk("clockwise", (m / 2 == 1) ? 1 : (m / 2 == 2) ? 0
                : 32'(dirPin == PCR_DIR_PIN_CW_LEVEL), 32'(cw));
        end
        $display("test direction done");
        for (int b = 0; b < 2; b++) begin
            word = PCR_SETTINGS_RESET | (32'(b) << 8);
            bus(1'b1, PCR_SETTINGS_ADDR, 4'hF, word, rd);
            alarmReq <= 1'b1;
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk("alarm pin", 32'(1 - b), 32'(alarmPin));
        end
        @(posedge clock);
        alarmReq <= 1'b0;
        $display("test alarm done");
        close_out();
    end
endmodule
`default_nettype wire
